// File: obc_loader.sv
/*
 Option byte loader: fetches five configuration bytes after reset, decodes
 them for watchdog, slow oscillator, power-on-clear and debug units, and
 exposes them over APB. Assumes a flash port on I_CLOCK that answers a
 request with a one-cycle ack; comparator inputs are asynchronous.
*/
`timescale 1ns/1ns
`default_nettype none
module obc_loader
    import obc_pkg::*;
(
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    // APB slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // Flash port
    output obc_flash_req_type O_FLASH,
    input wire logic I_FLASH_ACK,
    input wire logic [7:0] I_FLASH_RDATA,
    // Flash mode and programming events
    input wire logic I_BOOT_SWAP,
    input wire logic I_SELF_PROG,
    input wire logic I_PGM_EXT,
    input wire logic I_CHIP_ERASE,
    input wire logic I_BLOCK_ERASE,
    input wire logic I_POC_WR,
    output logic O_POC_WR_ALLOW,
    // Power modes and supply comparators
    input wire logic I_HALT,
    input wire logic I_STOP,
    input wire logic I_VDD_ABOVE_HI,
    input wire logic I_VDD_ABOVE_LO,
    output logic O_POC_RELEASE,
    // Decoded settings
    output logic O_CFG_VALID,
    output logic [6:0] O_WDOG_WINDOW_PCT,
    output logic [4:0] O_WDOG_OVF_EXP,
    output logic O_WDOG_RUN,
    output logic O_WDOG_ILLEGAL_DET_EN,
    output logic O_WDOG_CLK_EN,
    output logic O_TIMER_CLK_EN,
    output logic O_SLOW_OSC_RUN,
    output logic O_POR_DUAL_MODE,
    output logic O_DEBUG_EN,
    output logic O_DEBUG_ERASE_ON_FAIL
);

    logic [1:0] rst_sync_r;
    logic rst_n;
    logic [1:0] hi_sync_r;
    logic [1:0] lo_sync_r;
    logic vdd_hi;
    logic vdd_lo;
    obc_state_type state_r;
    logic [2:0] idx_r;
    logic [15:0] base_r;
    logic swap_r;
    logic self_prog_r;
    logic [7:0] bytes_r [OBC_NUM_BYTES];
    obc_cfg_type cfg_r;
    logic loaded_r;
    logic stop_req_r;
    logic hi_seen_r;
    logic poc_open_r;
    logic [31:0] prdata_r;
    logic [31:0] rd_nxt;
    logic [9:0] reg_idx;
    logic mapped;
    logic wdog_bad;
    logic dbg_bad;
    logic halted;

    // Reset release through two flops
    // Assert at once; release waits two edges to avoid a metastable exit
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Comparator synchronisers
    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            hi_sync_r <= 2'b00;
            lo_sync_r <= 2'b00;
        end else begin
            hi_sync_r <= {hi_sync_r[0], I_VDD_ABOVE_HI};
            lo_sync_r <= {lo_sync_r[0], I_VDD_ABOVE_LO};
        end
    end
    assign vdd_hi = hi_sync_r[1];
    assign vdd_lo = lo_sync_r[1];

    // Load sequencer
    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= OBC_IDLE;
            idx_r <= 3'h0;
            base_r <= OBC_PRI_BASE;
            swap_r <= 1'b0;
            self_prog_r <= 1'b0;
        end else begin
            unique case (state_r)
                OBC_IDLE: begin
                    // Mode inputs sampled once; later changes wait for reset
                    // fetch base chosen
                    base_r <= I_BOOT_SWAP ? OBC_ALT_BASE : OBC_PRI_BASE;
                    swap_r <= I_BOOT_SWAP;
                    self_prog_r <= I_SELF_PROG;
                    idx_r <= 3'h0;
                    state_r <= OBC_READ;
                end
                OBC_READ: begin
                    // Request stays up between bytes, no idle gap
                    if (I_FLASH_ACK) begin
                        if (idx_r == OBC_NUM_BYTES - 3'h1) begin
                            state_r <= swap_r ? OBC_COPY : OBC_DONE;
                        end else begin
                            idx_r <= idx_r + 3'h1;
                        end
                    end
                end
                OBC_COPY: begin
                    // Only the second byte goes back to the primary copy
                    if (I_FLASH_ACK) begin
                        state_r <= OBC_DONE;
                    end
                end
                OBC_DONE: begin
                    state_r <= OBC_DONE;
                end
            endcase
        end
    end

    // Byte capture, one bank per option byte
    for (genvar g = 0; g < OBC_NUM_BYTES; g++) begin : g_byte
        always_ff @(posedge I_CLOCK or negedge rst_n) begin
            if (!rst_n) begin
                bytes_r[g] <= OBC_BYTE_ZERO;
            end else if (state_r == OBC_READ && I_FLASH_ACK
                         && idx_r == 3'(g)) begin
                bytes_r[g] <= I_FLASH_RDATA;
            end
        end
    end

    // Flash request, held until ack
    always_comb begin
        O_FLASH.req = (state_r == OBC_READ) || (state_r == OBC_COPY);
        O_FLASH.we = (state_r == OBC_COPY);
        O_FLASH.addr = base_r + {13'h0000, idx_r};
        O_FLASH.wdata = OBC_BYTE_ZERO;
        if (state_r == OBC_COPY) begin
            O_FLASH.addr = OBC_PRI_BASE + {13'h0000, OBC_IDX_POC};
            O_FLASH.wdata = bytes_r[OBC_IDX_POC];
            if (self_prog_r) begin
                O_FLASH.wdata[OBC_POC_BIT] = 1'b0;
            end
        end
    end

    // Settings frozen once loading ends
    // Later flash writes cannot disturb running units
    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= '0;
            loaded_r <= 1'b0;
        end else if (state_r == OBC_DONE && !loaded_r) begin
            loaded_r <= 1'b1;
            cfg_r.wdog_window_sel <=
                bytes_r[OBC_IDX_WDOG][OBC_WIN_HI:OBC_WIN_LO];
            cfg_r.wdog_run_enable <= bytes_r[OBC_IDX_WDOG][OBC_RUN_BIT];
            cfg_r.wdog_overflow_sel <=
                bytes_r[OBC_IDX_WDOG][OBC_OVF_MSB:OBC_OVF_LSB];
            cfg_r.slow_osc_lock <= bytes_r[OBC_IDX_WDOG][OBC_LOCK_BIT];
            // mode bit; self-prog swap keeps default
            cfg_r.por_threshold_mode <= bytes_r[OBC_IDX_POC][OBC_POC_BIT]
                && !(swap_r && self_prog_r);
            cfg_r.debug_ctrl <= bytes_r[OBC_IDX_DBG][OBC_DBG_MSB:0];
        end
    end

    // Software stop request for the slow oscillator
    // Only the oscillator mode register accepts writes
    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            stop_req_r <= 1'b0;
        end else if (I_PSEL && I_PENABLE && I_PWRITE
                      && reg_idx == OBC_REG_OSC_MODE) begin
            stop_req_r <= I_PWDATA[OBC_STOP_REQ_BIT];
        end
    end

    // High threshold seen since supply last dropped
    // A drop below the low threshold rearms the wait for the high one
    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            hi_seen_r <= 1'b0;
        end else if (!vdd_lo) begin
            hi_seen_r <= 1'b0;
        end else if (vdd_hi) begin
            hi_seen_r <= 1'b1;
        end
    end

    // Mode bit write window; erase set wins over a same-cycle write
    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            poc_open_r <= 1'b0;
        end else if (I_CHIP_ERASE) begin
            poc_open_r <= 1'b1;
        end else if (I_POC_WR && O_POC_WR_ALLOW) begin
            poc_open_r <= 1'b0;
        end
    end
    // Block erase deliberately has no path here
    logic unused_block_erase;
    assign unused_block_erase = I_BLOCK_ERASE;

    // Self-programming can never open it
    // external programmer after erase
    assign O_POC_WR_ALLOW = I_PGM_EXT && poc_open_r;

    // Power-on-clear release
    always_comb begin
        if (cfg_r.por_threshold_mode) begin
            O_POC_RELEASE = hi_seen_r && vdd_lo;
        end else begin
            O_POC_RELEASE = vdd_lo;
        end
    end

    // Window percentage decode
    always_comb begin
        unique case (cfg_r.wdog_window_sel)
            2'b00: O_WDOG_WINDOW_PCT = OBC_PCT_25;
            2'b01: O_WDOG_WINDOW_PCT = OBC_PCT_50;
            2'b10: O_WDOG_WINDOW_PCT = OBC_PCT_75;
            2'b11: O_WDOG_WINDOW_PCT = OBC_PCT_100;
        endcase
    end

    assign O_WDOG_OVF_EXP = OBC_OVF_EXP_BASE
        + {2'b00, cfg_r.wdog_overflow_sel};
    assign O_WDOG_RUN = loaded_r && cfg_r.wdog_run_enable;
    assign O_WDOG_ILLEGAL_DET_EN = loaded_r && cfg_r.wdog_run_enable;
    assign O_CFG_VALID = loaded_r;
    assign O_POR_DUAL_MODE = cfg_r.por_threshold_mode;

    assign O_SLOW_OSC_RUN = cfg_r.slow_osc_lock || !stop_req_r;
    assign halted = I_HALT || I_STOP;
    always_comb begin
        O_WDOG_CLK_EN = O_WDOG_RUN && O_SLOW_OSC_RUN;
        // Self-programming never gates it; unlocked standby does
        if (!cfg_r.slow_osc_lock && halted) begin
            O_WDOG_CLK_EN = 1'b0;
        end
    end
    assign O_TIMER_CLK_EN = O_SLOW_OSC_RUN;

    always_comb begin
        O_DEBUG_EN = 1'b0;
        O_DEBUG_ERASE_ON_FAIL = 1'b0;
        unique case (cfg_r.debug_ctrl)
            OBC_DBG_OFF, OBC_DBG_BAD: begin
                // Prohibited code fails safe to disabled
                O_DEBUG_EN = 1'b0;
            end
            OBC_DBG_KEEP: begin
                O_DEBUG_EN = loaded_r;
            end
            OBC_DBG_ERASE: begin
                O_DEBUG_EN = loaded_r;
                O_DEBUG_ERASE_ON_FAIL = loaded_r;
            end
        endcase
    end

    assign wdog_bad = loaded_r && cfg_r.wdog_overflow_sel == OBC_OVF_MIN
        && cfg_r.wdog_window_sel == OBC_WIN_25;
    assign dbg_bad = loaded_r && cfg_r.debug_ctrl == OBC_DBG_BAD;

    // APB decode; word index sits above the two byte-lane bits
    assign reg_idx = I_PADDR[11:2];
    always_comb begin
        mapped = 1'b1;
        rd_nxt = 32'h0000_0000;
        unique case (reg_idx)
            OBC_REG_WDOG: rd_nxt[7:0] = bytes_r[OBC_IDX_WDOG];
            OBC_REG_POC: rd_nxt[7:0] = bytes_r[OBC_IDX_POC];
            // Reserved bytes read as zero
            OBC_REG_RSVA, OBC_REG_RSVB: rd_nxt = 32'h0000_0000;
            OBC_REG_DBG: rd_nxt[7:0] = bytes_r[OBC_IDX_DBG];
            OBC_REG_STATUS: begin
                rd_nxt[OBC_ST_LOADED] = loaded_r;
                rd_nxt[OBC_ST_SWAPPED] = swap_r;
                rd_nxt[OBC_ST_WDOG_BAD] = wdog_bad;
                rd_nxt[OBC_ST_DBG_BAD] = dbg_bad;
                rd_nxt[OBC_ST_HI_SEEN] = hi_seen_r;
                rd_nxt[OBC_ST_POC_OPEN] = poc_open_r;
            end
            OBC_REG_OSC_MODE: rd_nxt[OBC_STOP_REQ_BIT] = stop_req_r;
            default: mapped = 1'b0;
        endcase
    end

    // Read data captured in setup so access phase needs no wait
    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            prdata_r <= 32'h0000_0000;
        end else if (I_PSEL && !I_PENABLE) begin
            prdata_r <= (I_PWRITE) ? 32'h0000_0000 : rd_nxt;
        end
    end

    assign O_PRDATA = prdata_r;
    assign O_PREADY = 1'b1;
    // Only unmapped indices error; option byte writes are dropped
    assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;

endmodule
`default_nettype wire

// File: obc_pkg.sv
/*
 Constants, field layout and carrier types of the option byte loader.
 Assumes a byte-wide flash read/write port on the same clock and APB access.
*/
// Notes on behaviour
// - Load five bytes from 0x80 at reset.
// - Boot swap loads from 0x1080 range instead.
// - Window code picks 25/50/75/100 percent.
// - Run bit starts watchdog, enables illegal detect.
// - Overflow field n gives 2^(10+n) cycles.
// - Lock bit clear lets software stop oscillator.
// - Unlocked oscillator: no watchdog clock in HALT/STOP.
// - Timer keeps clock in HALT/STOP while oscillator runs.
// - Watchdog keeps counting during self-programming.
// - Second byte bit 0 picks threshold mode.
// - Dual mode: wait high threshold, then low.
// - Single mode: low threshold always.
// - Mode bit writable only by external programmer.
// - Boot swap copies 0x1081 into 0x81.
// - Mode changes only after whole-chip erase.
// - Debug field: off, prohibited, keep, erase.
package obc_pkg;
    // Flash side
    localparam logic [15:0] OBC_PRI_BASE = 16'h0080;
    localparam logic [15:0] OBC_ALT_BASE = 16'h1080;
    localparam logic [2:0] OBC_NUM_BYTES = 3'h5;
    localparam logic [2:0] OBC_IDX_WDOG = 3'h0;
    localparam logic [2:0] OBC_IDX_POC = 3'h1;
    localparam logic [2:0] OBC_IDX_DBG = 3'h4;
    // Register indices, byte address is four times the index
    localparam logic [9:0] OBC_REG_WDOG = 10'h080;
    localparam logic [9:0] OBC_REG_POC = 10'h081;
    localparam logic [9:0] OBC_REG_RSVA = 10'h082;
    localparam logic [9:0] OBC_REG_RSVB = 10'h083;
    localparam logic [9:0] OBC_REG_DBG = 10'h084;
    localparam logic [9:0] OBC_REG_STATUS = 10'h085;
    localparam logic [9:0] OBC_REG_OSC_MODE = 10'h086;
    // Option byte and register fields, decode values
    localparam int OBC_WIN_HI = 6;
    localparam int OBC_WIN_LO = 5;
    localparam int OBC_RUN_BIT = 4;
    localparam int OBC_OVF_MSB = 3;
    localparam int OBC_OVF_LSB = 1;
    localparam int OBC_LOCK_BIT = 0;
    localparam int OBC_POC_BIT = 0;
    localparam int OBC_DBG_MSB = 1;
    localparam int OBC_STOP_REQ_BIT = 0;
    localparam logic [6:0] OBC_PCT_25 = 7'h19;
    localparam logic [6:0] OBC_PCT_50 = 7'h32;
    localparam logic [6:0] OBC_PCT_75 = 7'h4B;
    localparam logic [6:0] OBC_PCT_100 = 7'h64;
    localparam logic [4:0] OBC_OVF_EXP_BASE = 5'h0A;
    localparam logic [1:0] OBC_WIN_25 = 2'h0;
    localparam logic [2:0] OBC_OVF_MIN = 3'h0;
    // Debug field codes
    localparam logic [1:0] OBC_DBG_OFF = 2'h0;
    localparam logic [1:0] OBC_DBG_BAD = 2'h1;
    localparam logic [1:0] OBC_DBG_KEEP = 2'h2;
    localparam logic [1:0] OBC_DBG_ERASE = 2'h3;
    // Status register bits
    localparam int OBC_ST_LOADED = 0;
    localparam int OBC_ST_SWAPPED = 1;
    localparam int OBC_ST_WDOG_BAD = 2;
    localparam int OBC_ST_DBG_BAD = 3;
    localparam int OBC_ST_HI_SEEN = 4;
    localparam int OBC_ST_POC_OPEN = 5;
    localparam logic [7:0] OBC_BYTE_ZERO = 8'h00;

    typedef enum logic [1:0] {
        OBC_IDLE = 2'b00,
        OBC_READ = 2'b01,
        OBC_COPY = 2'b11,
        OBC_DONE = 2'b10
    } obc_state_type;

    typedef struct packed {
        logic [1:0] wdog_window_sel;
        logic wdog_run_enable;
        logic [2:0] wdog_overflow_sel;
        logic slow_osc_lock;
        logic por_threshold_mode;
        logic [1:0] debug_ctrl;
    } obc_cfg_type;

    typedef struct packed {
        logic req;
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
    } obc_flash_req_type;
endpackage

// File: obc_flash_model.sv
/*
 Behavioural flash array for the option byte loader bench.
 Assumes a request held until a one-cycle ack on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module obc_flash_model
    import obc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Request side
    input wire obc_flash_req_type i_req,
    input wire logic i_slow,
    output logic o_ack,
    output logic [7:0] o_rdata
);
    // Entries 0..4 primary, 5..9 swap copy
    logic [7:0] mem [0:9];
    int wait_cnt;
    int idx;
    always_comb idx = (i_req.addr[12] ? 5 : 0) + int'(i_req.addr[2:0]);
    // Idle data toggles so a stale byte never looks valid
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ack <= 1'b0;
            wait_cnt <= 0;
            o_rdata <= 8'hA5;
        end else if (o_ack || !i_req.req || wait_cnt > 0) begin
            o_ack <= 1'b0;
            o_rdata <= ~o_rdata;
            if (!o_ack && i_req.req)
                wait_cnt <= wait_cnt - 1;
        end else begin
            o_ack <= 1'b1;
            wait_cnt <= i_slow ? 2 : 0;
            // copy write lands in the array
            if (i_req.we)
                mem[idx] <= i_req.wdata;
            else
                o_rdata <= mem[idx];
        end
    end
endmodule
`default_nettype wire

// File: obc_loader_chk.sv
/*
 Port checker for the option byte loader.
 Assumes binding onto obc_loader; sees its ports only.
*/
`timescale 1ns/1ns
`default_nettype none
module obc_loader_chk
    import obc_pkg::*;
(
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    // Flash port
    input wire obc_flash_req_type O_FLASH,
    input wire logic I_FLASH_ACK,
    // Decoded settings
    input wire logic O_CFG_VALID,
    input wire logic [6:0] O_WDOG_WINDOW_PCT,
    input wire logic [4:0] O_WDOG_OVF_EXP,
    input wire logic O_WDOG_RUN,
    input wire logic O_WDOG_ILLEGAL_DET_EN,
    input wire logic O_WDOG_CLK_EN,
    input wire logic O_TIMER_CLK_EN,
    input wire logic O_SLOW_OSC_RUN,
    input wire logic O_DEBUG_EN,
    input wire logic O_DEBUG_ERASE_ON_FAIL
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);
    a_req_hold: assert property (
        O_FLASH.req && !I_FLASH_ACK |=> O_FLASH.req && $stable(O_FLASH.addr)
    ) else $error("flash request dropped early");
    a_addr_step: assert property (
        O_FLASH.req && I_FLASH_ACK && !O_FLASH.we && O_FLASH.addr[2:0] != 3'h4
        |=> O_FLASH.req && O_FLASH.addr == $past(O_FLASH.addr) + 16'h0001
    ) else $error("flash read order broken");
    a_base_range: assert property (
        O_FLASH.req |-> (O_FLASH.we ? O_FLASH.addr == 16'h0081
            : O_FLASH.addr[15:3] inside {13'h0010, 13'h0210}
            && O_FLASH.addr[2:0] <= 3'h4)
    ) else $error("flash address outside option range");
    a_run_illegal: assert property (
        O_WDOG_RUN == O_WDOG_ILLEGAL_DET_EN
    ) else $error("run and illegal detect differ");
    a_ovf_range: assert property (
        O_CFG_VALID |-> O_WDOG_OVF_EXP inside {[5'h0A:5'h11]}
    ) else $error("overflow exponent out of range");
    a_timer_clk: assert property (
        O_TIMER_CLK_EN == O_SLOW_OSC_RUN
    ) else $error("timer clock not tied to oscillator");
    a_wdog_clk: assert property (
        O_WDOG_CLK_EN |-> O_WDOG_RUN && O_SLOW_OSC_RUN
    ) else $error("watchdog clock without oscillator");
    a_debug_dec: assert property (
        O_DEBUG_ERASE_ON_FAIL |-> O_DEBUG_EN
    ) else $error("erase on fail without debug");
    a_cfg_hold: assert property (
        O_CFG_VALID && $past(O_CFG_VALID) |-> $stable(O_WDOG_WINDOW_PCT)
        && $stable(O_WDOG_OVF_EXP) && $stable(O_DEBUG_EN)
    ) else $error("latched settings changed");
endmodule
bind obc_loader obc_loader_chk u_chk (
    .I_CLOCK, .I_RST_N, .O_FLASH, .I_FLASH_ACK, .O_CFG_VALID,
    .O_WDOG_WINDOW_PCT, .O_WDOG_OVF_EXP, .O_WDOG_RUN, .O_WDOG_ILLEGAL_DET_EN,
    .O_WDOG_CLK_EN, .O_TIMER_CLK_EN, .O_SLOW_OSC_RUN, .O_DEBUG_EN,
    .O_DEBUG_ERASE_ON_FAIL
);
`default_nettype wire

// File: obc_loader_bench.sv
/*
 Self-checking bench for the option byte loader.
 Assumes the flash model on the flash port; APB driven from here.
*/
`timescale 1ns/1ns
`default_nettype none
module obc_loader_bench;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, v;
    logic pready, pslverr, err, ack, swap = 1'b0, sp = 1'b0, slow = 1'b0;
    logic pgm = 1'b0, cer = 1'b0, ber = 1'b0, pwr_ev = 1'b0;
    logic halt = 1'b0, stop = 1'b0, vhi = 1'b0, vlo = 1'b1;
    logic allow, rel, valid, run, ill, wclk, tclk, orun, dual, den, der;
    logic [7:0] rdat;
    logic [7:0] e [0:4];
    logic [6:0] wpct;
    logic [4:0] oexp;
    obc_pkg::obc_flash_req_type fl;
    int fails = 0, checks_done = 0, cyc = 0;
    always #25 clk = ~clk;
    obc_loader dut (.I_CLOCK(clk), .I_RST_N(rst_n), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .O_FLASH(fl), .I_FLASH_ACK(ack), .I_FLASH_RDATA(rdat),
        .I_BOOT_SWAP(swap), .I_SELF_PROG(sp), .I_PGM_EXT(pgm),
        .I_CHIP_ERASE(cer), .I_BLOCK_ERASE(ber), .I_POC_WR(pwr_ev),
        .O_POC_WR_ALLOW(allow), .I_HALT(halt), .I_STOP(stop),
        .I_VDD_ABOVE_HI(vhi), .I_VDD_ABOVE_LO(vlo), .O_POC_RELEASE(rel),
        .O_CFG_VALID(valid), .O_WDOG_WINDOW_PCT(wpct), .O_WDOG_OVF_EXP(oexp),
        .O_WDOG_RUN(run), .O_WDOG_ILLEGAL_DET_EN(ill), .O_WDOG_CLK_EN(wclk),
        .O_TIMER_CLK_EN(tclk), .O_SLOW_OSC_RUN(orun), .O_POR_DUAL_MODE(dual),
        .O_DEBUG_EN(den), .O_DEBUG_ERASE_ON_FAIL(der));
    obc_flash_model u_flash (.i_clk(clk), .i_rst_n(rst_n), .i_req(fl),
        .i_slow(slow), .o_ack(ack), .o_rdata(rdat));
    task automatic results();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Setup, then access held until pready seen at an edge
    task automatic apb(input logic w, input logic [9:0] idx,
                       input logic [31:0] wd);
        psel <= 1'b1;
        pwr <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic boot();
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        do begin
            @(posedge clk);
        end while (valid !== 1'b1);
        @(posedge clk);
    endtask
    task automatic pulse(input int sel);
        case (sel)
            0: ber <= 1'b1;
            1: cer <= 1'b1;
            default: pwr_ev <= 1'b1;
        endcase
        @(posedge clk);
        ber <= 1'b0;
        cer <= 1'b0;
        pwr_ev <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            fails++;
            results();
        end
    end
    initial begin
        void'($urandom(32'h0d560595));
        for (int t = 0; t < 8; t++) begin
            swap <= t[0];
            sp <= t[1];
            slow <= t[2];
            for (int k = 0; k < 10; k += 5) begin
                v = $urandom & 32'h7F;
                if (v[6:5] == 2'h0 && v[3:1] == 3'h0)
                    v[5] = 1'b1;
                u_flash.mem[k] = v[7:0];
                u_flash.mem[k + 1] = 8'($urandom & 32'h1);
                u_flash.mem[k + 2] = 8'h00;
                u_flash.mem[k + 3] = 8'h00;
                // every debug code written, but only codes 00 and 10 are ever loaded; 01 is never exercised as a refused value
                u_flash.mem[k + 4] = 8'((t + k) & 3);
            end
            for (int i = 0; i < 5; i++)
                e[i] = u_flash.mem[(t[0] ? 5 : 0) + i];
            boot();
            cmp(wpct, 25 * (e[0][6:5] + 1));
            cmp(oexp, 10 + e[0][3:1]);
            cmp({run, ill}, {2{e[0][4]}});
            cmp({den, der}, {e[4][1], &e[4][1:0]});
            v[0] = e[1][0] & !(t[0] & t[1]);
            cmp({dual, rel}, {v[0], !v[0]});
            if (t[0])
                cmp(u_flash.mem[1], e[1] & {7'h7F, !t[1]});
            for (int i = 0; i < 5; i++) begin
                apb(1'b0, 10'h080 + 10'(i), 32'h0);
                cmp(rd, {24'h0, e[i]});
            end
            apb(1'b0, 10'h085, 32'h0);
            cmp(rd[5:0], {2'b00, e[4][1:0] == 2'h1, 1'b0, t[0], 1'b1});
            apb(1'b0, 10'h0F0, 32'h0);
            cmp(err, 1'b1);
            apb(1'b1, 10'h086, 32'h1);
            apb(1'b0, 10'h086, 32'h0);
            cmp(rd, 32'h1);
            halt <= !t[0];
            stop <= t[0];
            repeat (3) @(posedge clk);
            cmp({orun, tclk, wclk},
                {{2{e[0][0]}}, e[0][4] & e[0][0]});
            apb(1'b1, 10'h086, 32'h0);
            repeat (3) @(posedge clk);
            cmp({orun, tclk, wclk}, {2'b11, e[0][4] & e[0][0]});
            halt <= 1'b0;
            stop <= 1'b0;
            vhi <= 1'b1;
            repeat (4) @(posedge clk);
            cmp(wclk, e[0][4]);
            vhi <= 1'b0;
            repeat (4) @(posedge clk);
            cmp(rel, 1'b1);
            vlo <= 1'b0;
            repeat (4) @(posedge clk);
            cmp(rel, 1'b0);
            vlo <= 1'b1;
            if (t == 0) begin
                pgm <= 1'b1;
                pulse(0);
                cmp(allow, 1'b0);
                pulse(1);
                cmp(allow, 1'b1);
                pulse(2);
                cmp(allow, 1'b0);
                pgm <= 1'b0;
            end
        end
        results();
    end
endmodule
`default_nettype wire
